// *** hw/acs_pkg.sv ***
/*
 acs_pkg: shared types and constants of the converter control/status
 register block. Assumes one 16-bit host word per serial frame.
*/
package acs_pkg;
   localparam int WORD_W = 16;
   localparam int CTRL_W = 14;
   // write target codes carried in the two top bits of a host word
   localparam logic [1:0] TGT_NONE = 2'h0;
   localparam logic [1:0] TGT_TEST = 2'h1;
   localparam logic [1:0] TGT_CAL = 2'h2;
   localparam logic [1:0] TGT_CTRL = 2'h3;
   // readback selector codes
   localparam logic [1:0] RB_RESULT = 2'h0;
   localparam logic [1:0] RB_TEST = 2'h1;
   localparam logic [1:0] RB_CAL = 2'h2;
   localparam logic [1:0] RB_STATUS = 2'h3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;
   localparam logic [WORD_W-1:0] STAT_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] RDW_RESET = 16'h0000;
   localparam logic [3:0] RESULT_PAD = 4'h0;
   localparam logic [1:0] TEST_PAD = 2'h0;
   localparam logic [3:0] BIT_LAST = 4'hF;
   localparam logic [3:0] BIT_FIRST = 4'h0;
   // sleep_n and frame_n idle high, the word toggle idles low
   localparam logic [2:0] SYNC_IDLE = 3'h6;

   typedef struct packed {
      logic input_pairing_select;
      logic [2:0] channel_code;
      logic [1:0] power_down_sel;
      logic [1:0] readback_sel;
      logic iface_mode1;
      logic soft_convert_go;
      logic calib_scope;
      logic [1:0] calib_choice;
      logic calib_go;
   } acs_ctrl_s;

   typedef struct packed {
      logic zero;
      logic busy;
      logic input_pairing_select;
      logic [2:0] channel_code;
      logic [1:0] power_down_sel;
      logic [1:0] readback_sel;
      logic iface_mode1;
      logic dont_care;
      logic calib_scope;
      logic [1:0] calib_choice;
      logic calib_go;
   } acs_stat_s;

   typedef struct packed {
      logic [1:0] write_target;
      logic [CTRL_W-1:0] data;
   } acs_hword_s;

   // input indices 0..7 stand for analog_input 1..8
   typedef struct packed {
      logic [2:0] pos_sel;
      logic [2:0] neg_sel;
      logic neg_is_ground;
   } acs_mux_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_CAL = 3'b100
   } acs_st_e;

   function automatic acs_mux_s acs_chan_decode(input acs_ctrl_s c);
      acs_mux_s m;
      m.pos_sel = {c.channel_code[1:0], c.channel_code[2]};
      m.neg_sel = {c.channel_code[1:0], ~c.channel_code[2]};
      m.neg_is_ground = c.input_pairing_select;
      return m;
   endfunction

   function automatic acs_stat_s acs_status(input acs_ctrl_s c,
                                            input logic busy);
      acs_stat_s s;
      s = acs_stat_s'(STAT_RESET);
      s.busy = busy;
      s.input_pairing_select = c.input_pairing_select;
      s.channel_code = c.channel_code;
      s.power_down_sel = c.power_down_sel;
      s.readback_sel = c.readback_sel;
      s.iface_mode1 = c.iface_mode1;
      s.calib_scope = c.calib_scope;
      s.calib_choice = c.calib_choice;
      s.calib_go = c.calib_go;
      return s;
   endfunction
endpackage

// *** hw/acs_sync.sv ***
/*
 acs_sync: two-flop level synchroniser, W bits wide.
 Assumes each bit is an independent level or a toggle.
*/
`timescale 1ns/1ps
module acs_sync import acs_pkg::*; #(
   parameter int W = 1,
   // reset to each pin's idle level, so no false event follows reset
   parameter logic [W-1:0] IDLE = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s2;
      logic [W-1:0] s1;
   } acs_sync_s;
   acs_sync_s r_q, r_d;

   always_comb begin
      r_d.s1 = d;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_q <= '{s2: IDLE, s1: IDLE};
      end else begin
         r_q <= r_d;
      end
   end

   assign q = r_q.s2;
endmodule // acs_sync

// *** hw/acs_serial.sv ***
/*
 acs_serial: serial-clock side of the host port. Shifts in 16-bit
 words and shifts out the readback word. Assumes sclk only runs while
 frame_n is low and that rd_word and mode1 hold still during a frame.
*/
`timescale 1ns/1ps
module acs_serial import acs_pkg::*; (
   // link
   input wire logic sclk,
   input wire logic rst,
   input wire logic frame_n,
   input wire logic sdin,
   output logic sdout,
   output logic din_o,
   output logic din_oe_n,
   // toward system clock side
   input wire logic [WORD_W-1:0] rd_word,
   input wire logic mode1,
   output acs_hword_s word,
   output logic word_wr,
   output logic word_tgl
);
   // frame-scoped state, cleared whenever the frame is idle
   typedef struct packed {
      logic [3:0] cnt;
      logic [WORD_W-2:0] sh_in;
      logic [WORD_W-2:0] sh_out;
      logic m1;
      logic sdout;
      logic oe_n;
   } acs_frm_s;
   // state that must outlive the frame
   typedef struct packed {
      acs_hword_s word;
      logic wr;
      logic tgl;
   } acs_pers_s;
   acs_frm_s f_q, f_d;
   acs_pers_s p_q, p_d;

   always_comb begin
      f_d = f_q;
      p_d = p_q;
      f_d.cnt = f_q.cnt + 4'h1;
      f_d.sh_in = {f_q.sh_in[WORD_W-3:0], sdin};
      if (f_q.cnt == BIT_FIRST) begin
         f_d.m1 = mode1;
         f_d.sdout = rd_word[WORD_W-1];
         f_d.sh_out = rd_word[WORD_W-2:0];
         f_d.oe_n = ~mode1;
      end else begin
         f_d.sdout = f_q.sh_out[WORD_W-2];
         f_d.sh_out = {f_q.sh_out[WORD_W-3:0], 1'b0};
      end
      // word only handed over once all 16 bits are in
      if (f_q.cnt == BIT_LAST) begin
         p_d.word = acs_hword_s'({f_q.sh_in, sdin});
         p_d.wr = ~f_q.m1;
         p_d.tgl = ~p_q.tgl;
      end
   end

   // frame_n high aborts a partial word
   always_ff @(posedge sclk or posedge rst or posedge frame_n) begin
      if (rst || frame_n) begin
         f_q <= '{cnt: BIT_FIRST, sh_in: '0, sh_out: '0, m1: 1'b0,
                  sdout: 1'b0, oe_n: 1'b1};
      end else begin
         f_q <= f_d;
      end
   end

   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         p_q <= '0;
      end else begin
         p_q <= p_d;
      end
   end

   assign sdout = f_q.sdout;
   assign din_o = f_q.sdout;
   assign din_oe_n = f_q.oe_n;
   assign word = p_q.word;
   assign word_wr = p_q.wr;
   assign word_tgl = p_q.tgl;
endmodule // acs_serial

// *** hw/acs_regs.sv ***
/*
 acs_regs: control word, status word and readback selection of an
 eight-input 12-bit sampling converter, reached over a serial port.
 Assumes the converter core gives one-cycle done pulses on clk and
 that the host leaves 3 clk periods from frame_n low to first sclk.
*/
// Functional notes
// - control bit 13: 0 pseudo-differential pairs, 1 single-ended
// - bits 12..10 pick the channel; default input 1 plus, input 2 minus
// - differential codes 0-3 odd input positive, 4-7 polarity swapped
// - single-ended codes 0-3 odd inputs, 4-7 even; minus is ground
// - bits 9..8 with the sleep pin choose the power-down mode
// - bits 7..6 pick the register returned by all later reads
// - bit 5: 0 mode 2, 1 mode 1 where data-in also drives out
// - interface mode bit clears after every read cycle
// - bit 4 starts one conversion, self-clears when it finishes
// - bit 3: 0 self-calibration, 1 system calibration
// - bit 0 written 1 starts calibration of type bits 2..1
// - calibration-start bit self-clears when calibration completes
// - with bit 0 at 0, bits 2..1 address calibration registers
// - self types: 00 full, 01 gain+offset, 10 offset, 11 gain
// - system types: same order with system gain and offset
// - 16-bit read-only status word, selected by readback code 11
// - status word reads all zero after power-up
// - status layout: zero, busy, settings, don't-care, calibration bits
// - host word: two target bits, 14 data bits, applied when complete
// - readback 00 result, 01 test, 10 calibration, 11 status
// - control word is 14 bits, all zero after power-up
// - status bit 14 is 1 while converting or calibrating
`timescale 1ns/1ps
module acs_regs import acs_pkg::*; (
   // system clock
   input wire logic clk,
   input wire logic rst,
   // serial link
   input wire logic sclk,
   input wire logic frame_n,
   input wire logic sdin,
   output logic sdout,
   output logic din_o,
   output logic din_oe_n,
   // converter core inputs
   input wire logic sleep_n,
   input wire logic conv_done,
   input wire logic cal_done,
   input wire logic [11:0] conv_result,
   input wire logic [13:0] test_rd,
   input wire logic [15:0] cal_rd,
   // converter control
   output logic conv_start,
   output logic cal_start,
   output logic [2:0] cal_kind,
   output logic [1:0] cal_sel,
   output logic cal_ptr_rst,
   output acs_mux_s mux,
   output logic [1:0] pwr_sel,
   output logic sleep_req,
   output logic busy,
   // side registers
   output logic test_wr,
   output logic cal_wr,
   output logic [13:0] wr_data
);
   typedef struct packed {
      acs_ctrl_s ctrl;
      acs_st_e st;
      logic tgl;
      logic [WORD_W-1:0] rd_word;
      logic conv_start;
      logic cal_start;
      logic cal_ptr_rst;
      logic test_wr;
      logic cal_wr;
      logic [CTRL_W-1:0] wr_data;
      acs_mux_s mux;
      logic busy;
      logic sleep_req;
   } acs_top_s;

   acs_top_s r_q, r_d;
   acs_hword_s s_word;
   logic s_wr;
   logic s_tgl;
   logic [2:0] sy;
   logic sy_sleep_n;
   logic sy_frame_n;
   logic sy_tgl;
   logic new_word;
   acs_ctrl_s w_ctrl;
   acs_stat_s stat;

   acs_serial u_serial (
      .sclk(sclk),
      .rst(rst),
      .frame_n(frame_n),
      .sdin(sdin),
      .sdout(sdout),
      .din_o(din_o),
      .din_oe_n(din_oe_n),
      .rd_word(r_q.rd_word),
      .mode1(r_q.ctrl.iface_mode1),
      .word(s_word),
      .word_wr(s_wr),
      .word_tgl(s_tgl)
   );

   // word itself is held still by the link side, only the toggle crosses
   acs_sync #(.W(3), .IDLE(SYNC_IDLE)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({sleep_n, frame_n, s_tgl}),
      .q(sy)
   );

   assign sy_sleep_n = sy[2];
   assign sy_frame_n = sy[1];
   assign sy_tgl = sy[0];
   assign new_word = sy_tgl != r_q.tgl;
   assign w_ctrl = acs_ctrl_s'(s_word.data);
   assign stat = acs_status(r_q.ctrl, r_q.busy);

   always_comb begin
      r_d = r_q;
      r_d.conv_start = 1'b0;
      r_d.cal_start = 1'b0;
      r_d.cal_ptr_rst = 1'b0;
      r_d.test_wr = 1'b0;
      r_d.cal_wr = 1'b0;
      r_d.tgl = sy_tgl;
      r_d.sleep_req = ~sy_sleep_n;
      r_d.mux = acs_chan_decode(r_q.ctrl);
      unique case (r_q.st)
         ST_IDLE: begin
            r_d.st = ST_IDLE;
         end
         ST_CONV: begin
            if (conv_done) begin
               r_d.st = ST_IDLE;
               r_d.ctrl.soft_convert_go = 1'b0;
            end
         end
         ST_CAL: begin
            if (cal_done) begin
               r_d.st = ST_IDLE;
               r_d.ctrl.calib_go = 1'b0;
               r_d.ctrl.soft_convert_go = 1'b0;
            end
         end
         default: begin
            r_d.st = ST_IDLE;
         end
      endcase
      if (new_word) begin
         if (s_wr && s_word.write_target == TGT_CTRL) begin
            r_d.ctrl = w_ctrl;
            if (r_d.st != ST_IDLE) begin
               // go bits of a running job are not restarted
               r_d.ctrl.calib_go = r_q.ctrl.calib_go;
               r_d.ctrl.soft_convert_go = r_q.ctrl.soft_convert_go;
            end else if (w_ctrl.calib_go) begin
               r_d.st = ST_CAL;
               r_d.cal_start = 1'b1;
            end else if (w_ctrl.soft_convert_go) begin
               r_d.st = ST_CONV;
               r_d.conv_start = 1'b1;
            end
            if (!w_ctrl.calib_go) begin
               r_d.cal_ptr_rst = 1'b1;
            end
         end else begin
            // mode bit survives only the frame that rewrote it
            r_d.ctrl.iface_mode1 = 1'b0;
            r_d.wr_data = s_word.data;
            r_d.test_wr = s_wr && s_word.write_target == TGT_TEST;
            r_d.cal_wr = s_wr && s_word.write_target == TGT_CAL;
         end
      end
      r_d.busy = r_d.st != ST_IDLE;
      // freeze readback while a frame may be shifting it out
      if (sy_frame_n) begin
         unique case (r_q.ctrl.readback_sel)
            RB_RESULT: r_d.rd_word = {RESULT_PAD, conv_result};
            RB_TEST: r_d.rd_word = {TEST_PAD, test_rd};
            RB_CAL: r_d.rd_word = cal_rd;
            RB_STATUS: r_d.rd_word = stat;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_q.ctrl <= acs_ctrl_s'(CTRL_RESET);
         r_q.st <= ST_IDLE;
         r_q.tgl <= 1'b0;
         r_q.rd_word <= RDW_RESET;
         r_q.conv_start <= 1'b0;
         r_q.cal_start <= 1'b0;
         r_q.cal_ptr_rst <= 1'b0;
         r_q.test_wr <= 1'b0;
         r_q.cal_wr <= 1'b0;
         r_q.wr_data <= CTRL_RESET;
         r_q.mux <= '0;
         r_q.busy <= 1'b0;
         r_q.sleep_req <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   assign conv_start = r_q.conv_start;
   assign cal_start = r_q.cal_start;
   assign cal_kind = {r_q.ctrl.calib_scope, r_q.ctrl.calib_choice};
   assign cal_sel = r_q.ctrl.calib_choice;
   assign cal_ptr_rst = r_q.cal_ptr_rst;
   assign mux = r_q.mux;
   assign pwr_sel = r_q.ctrl.power_down_sel;
   assign sleep_req = r_q.sleep_req;
   assign busy = r_q.busy;
   assign test_wr = r_q.test_wr;
   assign cal_wr = r_q.cal_wr;
   assign wr_data = r_q.wr_data;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_conv_busy;
      conv_start |-> busy && r_q.st == ST_CONV && r_q.ctrl.soft_convert_go;
   endproperty
   a_conv_busy: assert property (p_conv_busy)
      else $error("conversion start without busy");

   property p_conv_clear;
      r_q.st == ST_CONV && conv_done && !new_word
         |=> !r_q.ctrl.soft_convert_go && !busy;
   endproperty
   a_conv_clear: assert property (p_conv_clear)
      else $error("convert bit not cleared at end");

   property p_cal_clear;
      r_q.st == ST_CAL && cal_done && !new_word
         |=> !r_q.ctrl.calib_go && !stat.busy;
   endproperty
   a_cal_clear: assert property (p_cal_clear)
      else $error("calibration start bit not cleared");

   property p_cal_start;
      cal_start |-> r_q.ctrl.calib_go && cal_kind == $past(
         {w_ctrl.calib_scope, w_ctrl.calib_choice});
   endproperty
   a_cal_start: assert property (p_cal_start)
      else $error("calibration started with wrong type");

   property p_mode_clear;
      new_word && !(s_wr && s_word.write_target == TGT_CTRL)
         |=> !r_q.ctrl.iface_mode1;
   endproperty
   a_mode_clear: assert property (p_mode_clear)
      else $error("interface mode bit kept after read");

   property p_ctrl_write;
      new_word && s_wr && s_word.write_target == TGT_CTRL
         |=> r_q.ctrl.channel_code == $past(w_ctrl.channel_code)
         && r_q.ctrl.readback_sel == $past(w_ctrl.readback_sel);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write)
      else $error("control word not applied");

   property p_mux;
      $stable(r_q.ctrl) ##1 $stable(r_q.ctrl)
         |-> mux.pos_sel[0] == r_q.ctrl.channel_code[2]
         && mux.neg_sel == (mux.pos_sel ^ 3'h1)
         && mux.neg_is_ground == r_q.ctrl.input_pairing_select;
   endproperty
   a_mux: assert property (p_mux)
      else $error("input selection disagrees with channel code");

   property p_busy;
      busy == (r_q.st != ST_IDLE) && stat.busy == busy;
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy flag wrong");

   property p_status;
      sy_frame_n && r_q.ctrl.readback_sel == RB_STATUS |=>
         r_q.rd_word[15] == 1'b0 && r_q.rd_word[14] == $past(busy)
         && r_q.rd_word[7:6] == RB_STATUS;
   endproperty
   a_status: assert property (p_status)
      else $error("status word readback wrong");

   property p_ptr;
      cal_ptr_rst |-> !r_q.ctrl.calib_go || r_q.st == ST_CAL;
   endproperty
   a_ptr: assert property (p_ptr)
      else $error("pointer reset with calibration start");

   property p_stat_reset;
      $past(rst) |-> stat == acs_stat_s'(STAT_RESET)
         && r_q.ctrl == acs_ctrl_s'(CTRL_RESET);
   endproperty
   a_stat_reset: assert property (p_stat_reset)
      else $error("status or control not zero after reset");

   property p_busy_fall;
      $fell(busy) |-> $past(conv_done || cal_done);
   endproperty
   a_busy_fall: assert property (p_busy_fall)
      else $error("busy dropped without a done pulse");

   property p_start_src;
      conv_start || cal_start |-> $past(new_word && s_wr
         && s_word.write_target == TGT_CTRL
         && (w_ctrl.soft_convert_go || w_ctrl.calib_go));
   endproperty
   a_start_src: assert property (p_start_src)
      else $error("job started without a control write");

   property p_ctrl_hold;
      !new_word && r_q.st == ST_IDLE |=> $stable(r_q.ctrl);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold)
      else $error("control settings changed without a write");

   property p_rd_freeze;
      !sy_frame_n |=> $stable(r_q.rd_word);
   endproperty
   a_rd_freeze: assert property (p_rd_freeze)
      else $error("readback word changed during a frame");

   property p_result;
      sy_frame_n && r_q.ctrl.readback_sel == RB_RESULT
         |=> r_q.rd_word == {RESULT_PAD, $past(conv_result)};
   endproperty
   a_result: assert property (p_result)
      else $error("result readback wrong");

   property p_side_wr;
      test_wr || cal_wr |-> $past(new_word && s_wr)
         && wr_data == $past(s_word.data) && !(test_wr && cal_wr);
   endproperty
   a_side_wr: assert property (p_side_wr)
      else $error("side register write without a full word");

   property p_sleep;
      sleep_req != $past(sy_sleep_n);
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep request does not follow the pin");

   c_conv: cover property (conv_start ##[1:200] conv_done);
   c_cal: cover property (cal_start ##[1:500] cal_done);
   c_status: cover property (r_q.ctrl.readback_sel == RB_STATUS && busy);
   c_mode1: cover property (r_q.ctrl.iface_mode1 ##1 new_word);
   c_sleep: cover property (sleep_req ##1 !sleep_req);
endmodule // acs_regs

// *** sim/acs_host.sv ***
/*
 acs_host: host model on the serial port of the converter registers.
 Assumes the bench resolves the data-in pin from din_oe_n and din_o.
*/
`timescale 1ns/1ps
module acs_host (
   // link out
   output logic sclk,
   output logic frame_n,
   output logic sdin_bit,
   // link in
   input wire logic sdout,
   input wire logic din_line,
   input wire logic din_oe_n
);
   // sclk stands still between frames
   initial begin
      sclk = 1'b0;
      frame_n = 1'b1;
      sdin_bit = 1'b0;
   end

   // one frame of nbits; in mode 1 the pin is read, so we toggle our bit instead of sending w
   task automatic xfer(input logic [15:0] w, input int nbits,
                       input logic m1, output logic [15:0] r,
                       output logic oe_low);
      r = 16'h0000;
      oe_low = 1'b0;
      frame_n = 1'b0;
      #400;
      for (int i = 15; i > 15 - nbits; i--) begin
         sdin_bit = m1 ? ~sdin_bit : w[i];
         #32 sclk = 1'b1;
         #30 r[i] = m1 ? din_line : sdout;
         if (din_oe_n === 1'b0) oe_low = 1'b1;
         #2 sclk = 1'b0;
      end
      frame_n = 1'b1;
      // released line shows no stale value
      sdin_bit = ~sdin_bit;
      #700;
   endtask
endmodule // acs_host

// *** sim/testbench.sv ***
/*
 testbench: drives acs_regs through the host model and a core stub,
 compares every full-word readback and the outputs with a behavioural model.
 Assumes acs_pkg and acs_host are compiled first.
*/
`timescale 1ns/1ps
module testbench import acs_pkg::*;;
   logic clk, rst, sleep_n, conv_done, cal_done;
   logic [11:0] conv_result;
   logic [13:0] test_rd, wr_data, m_ctrl;
   logic [15:0] cal_rd, pr;
   logic sclk, frame_n, sdin, sdout, din_o, din_oe_n, sdin_bit, po;
   logic conv_start, cal_start, cal_ptr_rst, sleep_req, busy;
   logic test_wr, cal_wr, m_busy;
   logic [2:0] cal_kind;
   logic [1:0] cal_sel, pwr_sel;
   acs_mux_s mux;
   int mismatches, tests_run, n_conv, n_cal, n_ptr, n_tw, n_cw;
   int e_conv, e_cal, e_ptr, e_tw, e_cw;
   integer seed;

   // data-in pin: device drives it only with enable low
   assign sdin = (din_oe_n === 1'b0) ? din_o : sdin_bit;

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   acs_regs dut (.clk(clk), .rst(rst), .sclk(sclk), .frame_n(frame_n),
      .sdin(sdin), .sdout(sdout), .din_o(din_o), .din_oe_n(din_oe_n),
      .sleep_n(sleep_n), .conv_done(conv_done), .cal_done(cal_done),
      .conv_result(conv_result), .test_rd(test_rd), .cal_rd(cal_rd),
      .conv_start(conv_start), .cal_start(cal_start),
      .cal_kind(cal_kind), .cal_sel(cal_sel), .cal_ptr_rst(cal_ptr_rst),
      .mux(mux), .pwr_sel(pwr_sel), .sleep_req(sleep_req), .busy(busy),
      .test_wr(test_wr), .cal_wr(cal_wr), .wr_data(wr_data));

   acs_host host (.sclk(sclk), .frame_n(frame_n), .sdin_bit(sdin_bit),
      .sdout(sdout), .din_line(sdin), .din_oe_n(din_oe_n));

   // pulse counters
   always @(posedge clk) begin
      if (conv_start === 1'b1) n_conv++;
      if (cal_start === 1'b1) n_cal++;
      if (cal_ptr_rst === 1'b1) n_ptr++;
      if (test_wr === 1'b1) n_tw++;
      if (cal_wr === 1'b1) n_cw++;
   end

   task automatic chk_rd(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] t=%0t read got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] t=%0t pin got=%h exp=%h", $time, g, e);
      end
   endtask

   function automatic logic [15:0] exp_rd();
      case (m_ctrl[7:6])
         2'h0: return {4'h0, conv_result};
         2'h1: return {2'h0, test_rd};
         2'h2: return cal_rd;
         default: return {1'b0, m_busy, m_ctrl[13:5], 1'b0, m_ctrl[3:0]};
      endcase
   endfunction

   task automatic chk_all();
      chk_pin(16'({mux.pos_sel, mux.neg_is_ground}),
              16'({m_ctrl[11:10], m_ctrl[12], m_ctrl[13]}));
      if (!m_ctrl[13])
         chk_pin(16'(mux.neg_sel), 16'({m_ctrl[11:10], ~m_ctrl[12]}));
      chk_pin(16'({pwr_sel, cal_kind, cal_sel}),
              16'({m_ctrl[9:8], m_ctrl[3:1], m_ctrl[2:1]}));
      chk_pin(16'(busy), 16'(m_busy));
      chk_pin(16'({8'(n_conv), 8'(n_cal)}),
              16'({8'(e_conv), 8'(e_cal)}));
      chk_pin(16'(n_ptr), 16'(e_ptr));
      chk_pin(16'({8'(n_tw), 8'(n_cw)}), 16'({8'(e_tw), 8'(e_cw)}));
   endtask

   // one full host word, with readback and model update
   task automatic word(input logic [15:0] w);
      logic [15:0] r, e;
      logic oe, m1;
      @(negedge clk);
      conv_result = 12'($random(seed));
      test_rd = 14'($random(seed));
      cal_rd = 16'($random(seed));
      repeat (3) @(negedge clk);
      m1 = m_ctrl[5];
      e = exp_rd();
      host.xfer(w, 16, m1, r, oe);
      chk_rd(r, e);
      chk_pin(16'(oe), 16'(m1));
      if (m1) m_ctrl[5] = 1'b0;
      else if (w[15:14] == TGT_CTRL) begin
         if (!w[0]) e_ptr++;
         if (m_busy) m_ctrl = {w[13:5], m_ctrl[4], w[3:1], m_ctrl[0]};
         else begin
            m_ctrl = w[13:0];
            if (w[0]) e_cal++;
            else if (w[4]) e_conv++;
            m_busy = w[0] | w[4];
         end
      end else begin
         // any other complete word is a read cycle
         m_ctrl[5] = 1'b0;
         if (w[15:14] == TGT_TEST) e_tw++;
         if (w[15:14] == TGT_CAL) e_cw++;
      end
      chk_all();
   endtask

   task automatic done(input logic cal);
      @(negedge clk);
      if (cal) cal_done = 1'b1;
      else conv_done = 1'b1;
      @(negedge clk);
      cal_done = 1'b0;
      conv_done = 1'b0;
      m_busy = 1'b0;
      m_ctrl[4] = 1'b0;
      if (cal) m_ctrl[0] = 1'b0;
      repeat (2) @(negedge clk);
      chk_all();
   endtask

   task automatic wrap_up();
      $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #1ms;
      mismatches++;
      wrap_up();
   end

   initial begin
      seed = 32'h866d;
      {rst, sleep_n} = 2'b11;
      {conv_done, cal_done, m_busy} = 3'b000;
      {conv_result, test_rd, cal_rd} = '0;
      {n_conv, n_cal, n_ptr, n_tw, n_cw} = '0;
      {e_conv, e_cal, e_ptr, e_tw, e_cw} = '0;
      {mismatches, tests_run} = '0;
      m_ctrl = CTRL_RESET;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk_pin(16'(sleep_req), 16'h0000);
      repeat (2) @(negedge clk);
      chk_pin(16'(din_oe_n), 16'h0001);
      chk_all();
      word(16'h0000);
      $display("test reset_defaults done");
      for (int c = 0; c < 16; c++) begin
         word({TGT_CTRL, 4'(c), 2'($random(seed)), RB_STATUS, 2'b00,
               3'($random(seed)), 1'b0});
         word(16'h0000);
      end
      $display("test channel_sweep done");
      for (int rb = 0; rb < 3; rb++) begin
         word({TGT_CTRL, 6'h00, 2'(rb), 6'h00});
         word(16'h0000);
         word(16'h0000);
      end
      $display("test readback_select done");
      word({TGT_TEST, 14'h2A5C});
      chk_pin(16'(wr_data), 16'h2A5C);
      word({TGT_CAL, 14'h15A3});
      chk_pin(16'(wr_data), 16'h15A3);
      word({TGT_NONE, 14'h3FFF});
      host.xfer(16'hFFFF, 8, 1'b0, pr, po);
      chk_all();
      $display("test targets_partial done");
      word({TGT_CTRL, 6'h00, RB_STATUS, 2'b01, 4'h0});
      word(16'h0000);
      word({TGT_CTRL, 6'h00, RB_STATUS, 2'b00, 4'h1});
      done(1'b0);
      word(16'h0000);
      $display("test conversion done");
      for (int k = 0; k < 8; k++) begin
         // odd k also sets the convert bit: calibration must win
         word({TGT_CTRL, 6'h00, RB_STATUS, 1'b0, 1'(k), 3'(k),
               1'b1});
         word(16'h0000);
         done(1'b1);
         word(16'h0000);
      end
      $display("test calibration done");
      word({TGT_CTRL, 6'h00, RB_STATUS, 1'b1, 5'h00});
      word(16'h0000);
      word(16'h0000);
      $display("test interface_mode done");
      @(negedge clk);
      sleep_n = 1'b0;
      repeat (4) @(negedge clk);
      chk_pin(16'(sleep_req), 16'h0001);
      sleep_n = 1'b1;
      repeat (4) @(negedge clk);
      chk_pin(16'(sleep_req), 16'h0000);
      $display("test sleep_pin done");
      wrap_up();
   end
endmodule // testbench
